// [fp_modulo_and_convert_unit.sv]
/*
 * floating multiply-and-separate plus precision and integer conversions,
 * with an apb status word holding mode bits, enables and condition flags.
 * assumes the sequencer holds operands only in the start cycle and reads
 * results on the done pulse one cycle later.
 */
`timescale 1ns/100ps
module fp_modulo_and_convert_unit (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic start,
	input wire fp_modconv_pkg::fp_op_t opcode,
	input wire logic [63:0] ac_operand,
	input wire logic [63:0] src_operand,
	input wire logic [31:0] int_operand,
	input wire logic [1:0] target_index,
	input wire logic reg_or_imm,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	output logic done,
	output logic [63:0] result_data,
	output logic result_write,
	output logic [63:0] int_part_data,
	output logic [1:0] int_part_index,
	output logic int_part_write,
	output logic trap_negzero,
	output logic trap_overflow,
	output logic trap_underflow,
	output logic [3:0] fp_flags
);
	typedef struct packed {
		logic [63:0] result;
		logic [63:0] int_part;
		logic [1:0] int_index;
		logic result_write;
		logic int_part_write;
		logic done;
		logic [2:0] trap;
		logic [2:0] last_trap;
		logic [15:0] status;
		logic [31:0] prdata;
		logic pslverr;
	} state_t;

	state_t cur_ff;
	state_t nxt_cur;

	logic dbl;
	logic chop;
	logic [6:0] keep;
	logic [63:0] ac_m;
	logic [63:0] src_m;
	logic [63:0] mant_a;
	logic [63:0] mant_b;
	logic [127:0] prod;
	logic [63:0] frac_f;
	logic signed [10:0] prod_exp;
	logic signed [10:0] kexp;
	logic prod_sign;
	logic prod_zero;
	logic prod_ovf;
	logic prod_unf;
	logic [31:0] int_val;
	logic [31:0] int_mag;
	logic [63:0] conv_src;
	logic conv_round;
	logic [63:0] int_mant;
	logic [63:0] norm_in;
	logic [63:0] norm_out;
	logic [6:0] norm_lz;
	logic norm_zero;
	logic [63:0] rnd_in;
	logic signed [10:0] rnd_exp_in;
	logic [6:0] rnd_keep;
	logic [63:0] rnd_mant;
	logic signed [10:0] rnd_exp;
	logic [63:0] op_result;
	logic [63:0] op_int;
	logic op_wr_result;
	logic op_wr_int;
	logic op_flag_upd;
	logic [3:0] op_flags;
	logic [2:0] op_trap;

	// mantissa with hidden bit, aligned to bit 63
	function automatic logic [63:0] mant_of(input logic [63:0] w);
		mant_of = {|w[62:55], w[54:0], 8'h00};
	endfunction

	// pack sign, exponent byte and normalised mantissa into a word
	function automatic logic [63:0] pack(input logic s, input logic [7:0] e,
		input logic [63:0] m);
		pack = {s, e, m[62:8]};
	endfunction

	fp_normalize u_norm (
		.mant_in(norm_in),
		.mant_out(norm_out),
		.lead_zeros(norm_lz),
		.is_zero(norm_zero)
	);

	fp_round u_round (
		.mant_in(rnd_in),
		.exp_in(rnd_exp_in),
		.keep(rnd_keep),
		.chop(chop),
		.mant_out(rnd_mant),
		.exp_out(rnd_exp)
	);

	assign dbl = cur_ff.status[fp_modconv_pkg::DOUBLE_BIT];
	assign chop = cur_ff.status[fp_modconv_pkg::CHOP_BIT];
	// precision length by mode
	assign keep = dbl ? fp_modconv_pkg::DOUBLE_KEEP : fp_modconv_pkg::SINGLE_KEEP;
	assign ac_m = dbl ? ac_operand : {ac_operand[63:32], 32'h0};
	assign src_m = dbl ? src_operand : {src_operand[63:32], 32'h0};
	assign mant_a = mant_of(ac_m);
	assign mant_b = mant_of(src_m);
	assign prod = mant_a * mant_b;

	// product kept to its top 64 bits, normalised by at most one place
	always_comb begin
		prod_exp = $signed({3'b000, ac_m[62:55]}) + $signed({3'b000, src_m[62:55]})
			- fp_modconv_pkg::EXP_BIAS;
		if (prod[127]) begin
			frac_f = prod[127:64];
		end else begin
			frac_f = prod[126:63];
			prod_exp = prod_exp - 11'sh001;
		end
		prod_sign = ac_m[63] ^ src_m[63];
		prod_zero = (ac_m[62:55] == 8'h00) || (src_m[62:55] == 8'h00);
		prod_ovf = !prod_zero && (prod_exp > fp_modconv_pkg::EXP_MAX);
		prod_unf = !prod_zero && (prod_exp <= 11'sh000);
		kexp = prod_exp - fp_modconv_pkg::EXP_BIAS;
	end

	// integer source sized by the long bit, register form left-justified
	always_comb begin
		if (!cur_ff.status[fp_modconv_pkg::LONG_BIT]) begin
			int_val = {{16{int_operand[15]}}, int_operand[15:0]};
		end else if (reg_or_imm) begin
			int_val = {int_operand[15:0], 16'h0000};
		end else begin
			int_val = int_operand;
		end
		int_mag = int_val[31] ? (32'h0 - int_val) : int_val;
	end

	// integer bits of the product, chopped to the precision length
	always_comb begin
		if (kexp > $signed({4'h0, keep})) begin
			int_mant = frac_f & ~(64'hffff_ffff_ffff_ffff >> keep);
		end else begin
			int_mant = frac_f & ~(64'hffff_ffff_ffff_ffff >> kexp[6:0]);
		end
	end

	// normaliser feeds the fraction part or the integer magnitude
	always_comb begin
		if (opcode == fp_modconv_pkg::op_load_int_to_float) begin
			norm_in = {int_mag, 32'h0};
		end else begin
			norm_in = frac_f << kexp[6:0];
		end
	end

	// rounder input selection per operation
	assign conv_src = (opcode == fp_modconv_pkg::op_store_prec_change) ? ac_operand : src_operand;
	assign conv_round = (opcode == fp_modconv_pkg::op_load_prec_change) ^ dbl;
	always_comb begin
		rnd_keep = keep;
		unique case (opcode)
			fp_modconv_pkg::op_mul_split_int_frac: begin
				if (kexp <= 11'sh000) begin
					rnd_in = frac_f;
					rnd_exp_in = prod_exp;
				end else begin
					rnd_in = norm_out;
					rnd_exp_in = fp_modconv_pkg::EXP_BIAS - $signed({4'h0, norm_lz});
				end
			end
			fp_modconv_pkg::op_load_int_to_float: begin
				rnd_in = norm_out;
				rnd_exp_in = fp_modconv_pkg::INT_EXP_BASE - $signed({4'h0, norm_lz});
			end
			default: begin
				rnd_in = mant_of(conv_src);
				rnd_exp_in = $signed({3'b000, conv_src[62:55]});
				rnd_keep = fp_modconv_pkg::SINGLE_KEEP;
			end
		endcase
	end

	// result, flags and traps of the operation presented with start
	always_comb begin
		op_result = 64'h0;
		op_int = 64'h0;
		op_wr_result = 1'b1;
		op_wr_int = 1'b0;
		op_flag_upd = 1'b1;
		op_trap = 3'h0;
		op_flags = 4'h0;
		unique case (opcode)
			fp_modconv_pkg::op_mul_split_int_frac: begin
				op_wr_int = !target_index[0];
				if (cur_ff.status[fp_modconv_pkg::NEGZERO_IE_BIT] && src_m[63]
					&& (src_m[62:55] == 8'h00)) begin
					op_wr_result = 1'b0;
					op_wr_int = 1'b0;
					op_flag_upd = 1'b0;
					op_trap[fp_modconv_pkg::TRAP_NEGZERO_BIT] = 1'b1;
				end else if (prod_zero) begin
					op_result = 64'h0;
				end else if (prod_ovf) begin
					if (cur_ff.status[fp_modconv_pkg::OVF_IE_BIT]) begin
						op_int = pack(prod_sign, prod_exp[7:0], int_mant);
						op_trap[fp_modconv_pkg::TRAP_OVERFLOW_BIT] = 1'b1;
					end
				end else if (prod_unf) begin
					if (cur_ff.status[fp_modconv_pkg::UNF_IE_BIT]) begin
						// exponent byte wraps, leaving it 256 too large
						op_result = pack(prod_sign, rnd_exp[7:0], rnd_mant);
						op_trap[fp_modconv_pkg::TRAP_UNDERFLOW_BIT] = 1'b1;
					end else begin
						op_result = 64'h0;
					end
				end else if (kexp <= 11'sh000) begin
					op_result = pack(prod_sign, rnd_exp[7:0], rnd_mant);
				end else if (kexp <= $signed({4'h0, keep})) begin
					op_int = pack(prod_sign, prod_exp[7:0], int_mant);
					if (!norm_zero) begin
						op_result = pack(prod_sign, rnd_exp[7:0], rnd_mant);
					end
				end else begin
					op_int = pack(prod_sign, prod_exp[7:0], int_mant);
				end
				op_flags[fp_modconv_pkg::OVERFLOW_BIT] = prod_ovf;
				op_flags[fp_modconv_pkg::ZERO_BIT] = (op_result[62:55] == 8'h00);
				op_flags[fp_modconv_pkg::NEGATIVE_BIT] = op_result[63];
			end
			fp_modconv_pkg::op_load_int_to_float: begin
				if (!norm_zero) begin
					op_result = pack(int_val[31], rnd_exp[7:0], rnd_mant);
				end
				op_flags[fp_modconv_pkg::ZERO_BIT] = (op_result[62:55] == 8'h00);
				op_flags[fp_modconv_pkg::NEGATIVE_BIT] = op_result[63];
			end
			default: begin
				if ((opcode == fp_modconv_pkg::op_load_prec_change) && conv_src[63]
					&& (conv_src[62:55] == 8'h00)
					&& cur_ff.status[fp_modconv_pkg::NEGZERO_IE_BIT]) begin
					op_wr_result = 1'b0;
					op_trap[fp_modconv_pkg::TRAP_NEGZERO_BIT] = 1'b1;
					op_flags[fp_modconv_pkg::ZERO_BIT] = 1'b1;
					op_flags[fp_modconv_pkg::NEGATIVE_BIT] = 1'b1;
				end else begin
					if (conv_src[62:55] == 8'h00) begin
						op_result = 64'h0;
					end else if (!conv_round) begin
						op_result = {conv_src[63:32], 32'h0};
					end else if (rnd_exp > fp_modconv_pkg::EXP_MAX) begin
						op_flags[fp_modconv_pkg::OVERFLOW_BIT] = 1'b1;
						if (cur_ff.status[fp_modconv_pkg::OVF_IE_BIT]) begin
							// carried mantissa packs to a signed zero
							op_result = pack(conv_src[63], rnd_exp[7:0], rnd_mant);
							op_trap[fp_modconv_pkg::TRAP_OVERFLOW_BIT] = 1'b1;
						end else begin
							op_result = 64'h0;
						end
					end else begin
						op_result = pack(conv_src[63], rnd_exp[7:0], rnd_mant);
					end
					op_flags[fp_modconv_pkg::ZERO_BIT] = (op_result[62:55] == 8'h00);
					op_flags[fp_modconv_pkg::NEGATIVE_BIT] = op_result[63];
				end
			end
		endcase
	end

	// next state: apb access, then the operation taken this cycle
	always_comb begin
		nxt_cur = cur_ff;
		nxt_cur.done = 1'b0;
		nxt_cur.result_write = 1'b0;
		nxt_cur.int_part_write = 1'b0;
		nxt_cur.trap = 3'h0;
		if (psel && !penable) begin
			nxt_cur.prdata = 32'h0;
			nxt_cur.pslverr = 1'b0;
			unique case (paddr)
				fp_modconv_pkg::STATUS_WORD_OFFSET: nxt_cur.prdata = {16'h0, cur_ff.status};
				fp_modconv_pkg::TRAP_CAUSE_OFFSET: nxt_cur.prdata = {29'h0, cur_ff.last_trap};
				default: nxt_cur.pslverr = 1'b1;
			endcase
		end
		if (psel && penable && pwrite && (paddr == fp_modconv_pkg::STATUS_WORD_OFFSET)) begin
			nxt_cur.status = (cur_ff.status & ~fp_modconv_pkg::STATUS_WORD_WR_MASK)
				| (pwdata[15:0] & fp_modconv_pkg::STATUS_WORD_WR_MASK);
		end
		// operation results land one cycle after start; flags beat a bus write
		if (start) begin
			nxt_cur.done = 1'b1;
			nxt_cur.trap = op_trap;
			nxt_cur.last_trap = op_trap;
			nxt_cur.result_write = op_wr_result;
			nxt_cur.int_part_write = op_wr_int;
			nxt_cur.int_index = target_index | 2'h1;
			if (op_wr_result) begin
				nxt_cur.result = op_result;
			end
			if (op_wr_int) begin
				nxt_cur.int_part = op_int;
			end
			if (op_flag_upd) begin
				nxt_cur.status[3:0] = op_flags;
			end
		end
	end

	// state register
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cur_ff <= '0;
			cur_ff.status <= fp_modconv_pkg::STATUS_WORD_RESET;
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	// outputs
	assign pready = psel && penable; // zero wait states
	assign prdata = cur_ff.prdata;
	assign pslverr = cur_ff.pslverr && psel && penable;
	assign done = cur_ff.done;
	assign result_data = cur_ff.result;
	assign result_write = cur_ff.result_write;
	assign int_part_data = cur_ff.int_part;
	assign int_part_index = cur_ff.int_index;
	assign int_part_write = cur_ff.int_part_write;
	assign trap_negzero = cur_ff.trap[fp_modconv_pkg::TRAP_NEGZERO_BIT];
	assign trap_overflow = cur_ff.trap[fp_modconv_pkg::TRAP_OVERFLOW_BIT];
	assign trap_underflow = cur_ff.trap[fp_modconv_pkg::TRAP_UNDERFLOW_BIT];
	assign fp_flags = cur_ff.status[3:0];
endmodule

// [fp_modconv_pkg.sv]
/*
 * constants and types shared by the floating modulo and conversion datapath.
 * assumes the 64-bit floating word layout: sign in bit 63, excess-128
 * exponent in bits 62:55, fraction in bits 54:0 with a hidden leading one;
 * single precision uses the upper 32 bits only.
 */
package fp_modconv_pkg;

	typedef enum logic [1:0] {
		op_mul_split_int_frac,
		op_load_prec_change,
		op_store_prec_change,
		op_load_int_to_float
	} fp_op_t;

	// apb register offsets
	localparam logic [7:0] STATUS_WORD_OFFSET = 8'h00;
	localparam logic [7:0] TRAP_CAUSE_OFFSET = 8'h04;

	// status word fields
	localparam int CARRY_BIT = 0;
	localparam int OVERFLOW_BIT = 1;
	localparam int ZERO_BIT = 2;
	localparam int NEGATIVE_BIT = 3;
	localparam int CHOP_BIT = 5;
	localparam int LONG_BIT = 6;
	localparam int DOUBLE_BIT = 7;
	localparam int OVF_IE_BIT = 9;
	localparam int UNF_IE_BIT = 10;
	localparam int NEGZERO_IE_BIT = 11;
	localparam logic [15:0] STATUS_WORD_WR_MASK = 16'h0eef;
	localparam logic [15:0] STATUS_WORD_RESET = 16'h0000;

	// trap cause fields
	localparam int TRAP_NEGZERO_BIT = 0;
	localparam int TRAP_OVERFLOW_BIT = 1;
	localparam int TRAP_UNDERFLOW_BIT = 2;

	// number format
	localparam logic signed [10:0] EXP_BIAS = 11'sh080;
	localparam logic signed [10:0] EXP_MAX = 11'sh0ff;
	localparam logic signed [10:0] INT_EXP_BASE = 11'sh0a0;
	localparam logic [6:0] SINGLE_KEEP = 7'h18;
	localparam logic [6:0] DOUBLE_KEEP = 7'h38;

endpackage

// [fp_normalize.sv]
/*
 * leading-zero normaliser for a 64-bit mantissa.
 * assumes a purely combinational use inside the datapath.
 */
`timescale 1ns/100ps
module fp_normalize (
	input wire logic [63:0] mant_in,
	output logic [63:0] mant_out,
	output logic [6:0] lead_zeros,
	output logic is_zero
);
	// count zeros above the first one, then shift it to bit 63
	always_comb begin
		lead_zeros = 7'h40;
		for (int i = 0; i < 64; i++) begin
			if (mant_in[i]) begin
				lead_zeros = 7'(63 - i);
			end
		end
		is_zero = (mant_in == 64'h0);
		mant_out = mant_in << lead_zeros;
	end
endmodule

// [fp_round.sv]
/*
 * rounds or chops a normalised 64-bit mantissa to a kept length.
 * assumes the mantissa has bit 63 set unless it is zero.
 */
`timescale 1ns/100ps
module fp_round (
	input wire logic [63:0] mant_in,
	input wire logic signed [10:0] exp_in,
	input wire logic [6:0] keep,
	input wire logic chop,
	output logic [63:0] mant_out,
	output logic signed [10:0] exp_out
);
	logic [63:0] keep_mask;
	logic [63:0] half_lsb;
	logic [64:0] sum;

	// add half an lsb unless chopping; a carry out renormalises upward
	always_comb begin
		keep_mask = ~(64'hffff_ffff_ffff_ffff >> keep);
		half_lsb = 64'h8000_0000_0000_0000 >> keep;
		sum = {1'b0, mant_in} + (chop ? 65'h0 : {1'b0, half_lsb});
		if (sum[64]) begin
			mant_out = 64'h8000_0000_0000_0000;
			exp_out = exp_in + 11'sh001;
		end else begin
			mant_out = sum[63:0] & keep_mask;
			exp_out = exp_in;
		end
	end
endmodule

// [fp_modconv_assertions.sv]
/*
 * port checker for the floating modulo and conversion unit.
 * assumes it is bound to the unit and sees only its ports.
 */
`timescale 1ns/100ps
module fp_modconv_assertions (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic start,
	input wire fp_modconv_pkg::fp_op_t opcode,
	input wire logic [1:0] target_index,
	input wire logic done,
	input wire logic [63:0] result_data,
	input wire logic result_write,
	input wire logic [1:0] int_part_index,
	input wire logic int_part_write,
	input wire logic trap_negzero,
	input wire logic trap_overflow,
	input wire logic trap_underflow,
	input wire logic [3:0] fp_flags
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	// handshake timing, write gating, trap and flag rules
	property p_done_lat;
		start |=> done;
	endproperty
	a_done_lat: assert property (p_done_lat) else $error("done late");
	property p_no_done;
		!start |=> !done;
	endproperty
	a_no_done: assert property (p_no_done) else $error("done without start");
	property p_odd_drop;
		start && opcode == fp_modconv_pkg::op_mul_split_int_frac && target_index[0] |=> !int_part_write;
	endproperty
	a_odd_drop: assert property (p_odd_drop) else $error("odd target wrote");
	property p_int_idx;
		int_part_write |-> int_part_index[0] && done;
	endproperty
	a_int_idx: assert property (p_int_idx) else $error("integer part index");
	property p_int_load;
		start && opcode == fp_modconv_pkg::op_load_int_to_float
			|=> !(trap_negzero || trap_overflow || trap_underflow) && fp_flags[1:0] == 2'b00;
	endproperty
	a_int_load: assert property (p_int_load) else $error("integer load trap");
	property p_store_nz;
		start && opcode == fp_modconv_pkg::op_store_prec_change |=> !trap_negzero;
	endproperty
	a_store_nz: assert property (p_store_nz) else $error("store trapped");
	property p_carry;
		done && !trap_negzero |-> !fp_flags[0];
	endproperty
	a_carry: assert property (p_carry) else $error("carry set");
	property p_zn;
		done && result_write |-> fp_flags[3:2] == {result_data[63], result_data[62:55] == 8'h00};
	endproperty
	a_zn: assert property (p_zn) else $error("zero or negative flag");
	property p_nz_block;
		trap_negzero |-> !result_write && !int_part_write;
	endproperty
	a_nz_block: assert property (p_nz_block) else $error("write after trap");
	property p_unf_mul;
		start && opcode != fp_modconv_pkg::op_mul_split_int_frac |=> !trap_underflow;
	endproperty
	a_unf_mul: assert property (p_unf_mul) else $error("underflow trap");
	property p_ovf_flag;
		trap_overflow |-> fp_flags[1];
	endproperty
	a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag");

	// main scenarios reached
	c_nz: cover property (trap_negzero);
	c_ovf: cover property (trap_overflow);
	c_unf: cover property (trap_underflow);
	c_int: cover property (int_part_write);
endmodule

// [fp_seq_model.sv]
/*
 * sequencer model issuing one operation at a time to the unit.
 * assumes issue is called from one bench thread, clocked by clk.
 */
`timescale 1ns/100ps
module fp_seq_model (
	input wire logic clk,
	output logic start,
	output fp_modconv_pkg::fp_op_t opcode,
	output logic [63:0] ac_operand,
	output logic [63:0] src_operand,
	output logic [31:0] int_operand,
	output logic [1:0] target_index,
	output logic reg_or_imm
);
	// idle values at time zero
	initial begin
		start = 1'b0;
		opcode = fp_modconv_pkg::op_mul_split_int_frac;
		ac_operand = 64'h0;
		src_operand = 64'h0;
		int_operand = 32'h0;
		target_index = 2'h0;
		reg_or_imm = 1'b0;
	end

	// operands valid with the strobe only, then scrambled
	task automatic issue(input fp_modconv_pkg::fp_op_t o, input logic [63:0] a,
		input logic [63:0] s, input logic [31:0] i, input logic [1:0] t, input logic r);
		@(posedge clk);
		start <= 1'b1;
		opcode <= o;
		ac_operand <= a;
		src_operand <= s;
		int_operand <= i;
		target_index <= t;
		reg_or_imm <= r;
		@(posedge clk);
		start <= 1'b0;
		ac_operand <= ~a;
		src_operand <= ~s;
		int_operand <= ~i;
	endtask
endmodule

// [tb_top.sv]
/*
 * self-checking bench for the floating modulo and conversion unit.
 * assumes the sequencer model drives the operation port.
 */
`timescale 1ns/100ps
module tb_top;
	logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, done;
	logic start, reg_or_imm, result_write, int_part_write, iw, r, e;
	logic trap_negzero, trap_overflow, trap_underflow;
	fp_modconv_pkg::fp_op_t opcode;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, int_operand, v, q;
	logic [63:0] ac_operand, src_operand, result_data, int_part_data, x, s;
	logic [1:0] target_index, int_part_index;
	logic [3:0] fp_flags;
	longint iv;
	int mismatches, n_checks, cycles;

	fp_seq_model seq_u (.clk, .start, .opcode, .ac_operand, .src_operand, .int_operand,
		.target_index, .reg_or_imm);
	fp_modulo_and_convert_unit dut_u (.clk, .sys_rst, .start, .opcode, .ac_operand,
		.src_operand, .int_operand, .target_index, .reg_or_imm, .psel, .penable, .pwrite,
		.paddr, .pwdata, .pready, .prdata, .pslverr, .done, .result_data, .result_write,
		.int_part_data, .int_part_index, .int_part_write, .trap_negzero, .trap_overflow,
		.trap_underflow, .fp_flags);

	// clock and hang limit
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			mismatches++;
			complete_run();
		end
	end

	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic check(input string n, input logic [63:0] sn, input logic [63:0] ex);
		n_checks++;
		if (sn !== ex) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", n, ex, sn);
		end
	endtask

	// model of the number formats
	function automatic logic [63:0] to_f(input longint a);
		longint m;
		int p;
		logic [63:0] y;
		m = (a < 0) ? -a : a;
		p = 0;
		y = 64'h0;
		for (int b = 0; b < 40; b++)
			if (m[b]) p = b;
		if (m != 0) begin
			y[63] = a < 0;
			y[62:55] = 8'(129 + p);
			y[54:0] = 55'(m << (55 - p));
		end
		return y;
	endfunction
	function automatic logic [63:0] hi(input logic [63:0] y);
		return {y[63:32], 32'h0};
	endfunction
	function automatic logic [63:0] rnd(input logic [63:0] y);
		return {y[63:32] + {31'h0, y[31]}, 32'h0};
	endfunction
	function automatic logic [3:0] fl(input logic [63:0] y);
		return {y[63], y[62:55] == 8'h00, 2'b00};
	endfunction

	// apb transfer held until pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic er);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// wait for the slave; only the bench's cycle ceiling ends a hang
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic setm(input logic [31:0] d);
		apb(1'b1, 8'h00, d, q, e);
	endtask

	// one operation and its port results
	task automatic run(input fp_modconv_pkg::fp_op_t o, input logic [63:0] a,
		input logic [63:0] b, input logic [31:0] i, input logic [1:0] t, input logic ri,
		input logic ew, input logic [63:0] mk, input logic [63:0] er, input logic [3:0] ef,
		input logic [2:0] et);
		seq_u.issue(o, a, b, i, t, ri);
		@(negedge clk);
		iw = int_part_write;
		check("done", 64'(done), 64'h1);
		check("write", 64'(result_write), 64'(ew));
		check("result", result_data & mk, er);
		check("flags", 64'(fp_flags & mk[3:0]), 64'(ef));
		check("traps", 64'({trap_underflow, trap_overflow, trap_negzero}), 64'(et));
	endtask

	// main sequence
	initial begin
		sys_rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		mismatches = 0;
		n_checks = 0;
		void'($urandom(20));
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		apb(1'b0, 8'h00, 32'h0, q, e);
		check("status reset", 64'(q), 64'h0);
		setm(32'hffffffff);
		apb(1'b0, 8'h00, 32'h0, q, e);
		check("status mask", 64'(q), 64'h0eef);
		apb(1'b0, 8'h10, 32'h0, q, e);
		check("unmapped", 64'({e, q}), 64'h1_0000_0000);
		for (int k = 0; k < 16; k++) begin
			setm({24'h0, k[2:0], 5'h0});
			v = $urandom;
			r = 1'($urandom);
			iv = !k[1] ? $signed(v[15:0]) : (r ? $signed({v[15:0], 16'h0}) : $signed(v));
			x = to_f(iv);
			if (!k[2]) x = k[0] ? hi(x) : rnd(x);
			run(fp_modconv_pkg::op_load_int_to_float, 64'h0, 64'h0, v, 2'h0, r, 1'b1, '1, x,
				fl(x), 3'h0);
		end
		for (int k = 0; k < 8; k++) begin
			setm({24'h0, k[1], 1'b0, k[0], 5'h0});
			s = {$urandom, $urandom};
			s[62:55] = 8'($urandom_range(1, 254));
			x = (k[1] || k[0]) ? hi(s) : rnd(s);
			run(fp_modconv_pkg::op_load_prec_change, 64'h0, s, 32'h0, 2'h0, 1'b0, 1'b1, '1, x,
				fl(x), 3'h0);
			x = (k[1] && !k[0]) ? rnd(s) : hi(s);
			run(fp_modconv_pkg::op_store_prec_change, s, 64'h0, 32'h0, 2'h0, 1'b0, 1'b1, '1, x,
				fl(x), 3'h0);
		end
		setm(32'h0);
		run(fp_modconv_pkg::op_load_prec_change, 64'h0, 64'h0000_ffff_ffff_ffff, 32'h0, 2'h0,
			1'b0, 1'b1, '1, 64'h0, 4'h4, 3'h0);
		run(fp_modconv_pkg::op_load_prec_change, 64'h0, 64'h7fff_ffff_ffff_ffff, 32'h0, 2'h0,
			1'b0, 1'b1, '1, 64'h0, 4'h6, 3'h0);
		run(fp_modconv_pkg::op_load_prec_change, 64'h0, 64'h8000_0000_0000_0000, 32'h0, 2'h0,
			1'b0, 1'b1, '1, 64'h0, 4'h4, 3'h0);
		setm(32'h0800);
		run(fp_modconv_pkg::op_load_prec_change, 64'h0, 64'h8000_0000_0000_0000, 32'h0, 2'h0,
			1'b0, 1'b0, '1, 64'h0, 4'hc, 3'h1);
		apb(1'b0, 8'h04, 32'h0, q, e);
		check("trap cause", 64'(q), 64'h1);
		run(fp_modconv_pkg::op_store_prec_change, 64'h8000_0000_0000_0000, 64'h0, 32'h0, 2'h0,
			1'b0, 1'b1, '1, 64'h0, 4'h4, 3'h0);
		setm(32'h0200);
		run(fp_modconv_pkg::op_load_prec_change, 64'h0, 64'h7fff_ffff_ffff_ffff, 32'h0, 2'h0,
			1'b0, 1'b1, 64'h7fff_ffff_ffff_fff7, 64'h0, 4'h6, 3'h2);
		setm(32'h0280);
		run(fp_modconv_pkg::op_store_prec_change, 64'h7fff_ffff_ffff_ffff, 64'h0, 32'h0, 2'h0,
			1'b0, 1'b1, 64'h7fff_ffff_ffff_fff7, 64'h0, 4'h6, 3'h2);
		setm(32'h0080);
		run(fp_modconv_pkg::op_store_prec_change, 64'h7fff_ffff_ffff_ffff, 64'h0, 32'h0, 2'h0,
			1'b0, 1'b1, '1, 64'h0, 4'h6, 3'h0);
		for (int k = 0; k < 7; k++) begin
			setm({24'h0, k[2], 7'h0});
			iv = (k == 6) ? 1 : 2 * $urandom_range(1, 1023) + 1;
			run(fp_modconv_pkg::op_mul_split_int_frac, to_f(iv), 64'h4000_0000_0000_0000,
				32'h0, 2'(k), 1'b0, 1'b1, '1, 64'h4000_0000_0000_0000, 4'h0, 3'h0);
			check("int write", 64'(iw), 64'(!k[0]));
			if (!k[0]) check("int part", int_part_data, to_f(iv >>> 1));
			if (!k[0]) check("int index", 64'(int_part_index), 64'(k[1:0] | 2'h1));
		end
		// product overflow, interrupt off then on: exponent wraps down by 256
		for (int k = 0; k < 2; k++) begin
			setm({22'h0, k[0], 9'h0});
			run(fp_modconv_pkg::op_mul_split_int_frac, 64'h7f80_0000_0000_0000,
				64'h7f80_0000_0000_0000, 32'h0, 2'h0, 1'b0, 1'b1, '1, 64'h0, 4'h6,
				{1'b0, k[0], 1'b0});
			check("int part", int_part_data, k[0] ? 64'h3e80_0000_0000_0000 : 64'h0);
		end
		setm(32'h0);
		run(fp_modconv_pkg::op_mul_split_int_frac, 64'h0080_0000_0000_0000,
			64'h0080_0000_0000_0000, 32'h0, 2'h0, 1'b0, 1'b1, '1, 64'h0, 4'h4, 3'h0);
		check("int part", int_part_data, 64'h0);
		setm(32'h0400);
		run(fp_modconv_pkg::op_mul_split_int_frac, 64'h0080_0000_0000_0000,
			64'h0080_0000_0000_0000, 32'h0, 2'h0, 1'b0, 1'b1, '1, 64'h4080_0000_0000_0000,
			4'h0, 3'h4);
		check("int part", int_part_data, 64'h0);
		setm(32'h0800);
		run(fp_modconv_pkg::op_mul_split_int_frac, to_f(3), 64'h8000_0000_0000_0000, 32'h0,
			2'h0, 1'b0, 1'b0, '1, 64'h4080_0000_0000_0000, 4'h0, 3'h1);
		check("int write", 64'(iw), 64'h0);
		complete_run();
	end
endmodule

bind fp_modulo_and_convert_unit fp_modconv_assertions chk_u (.clk, .sys_rst, .start,
	.opcode, .target_index, .done, .result_data, .result_write, .int_part_index,
	.int_part_write, .trap_negzero, .trap_overflow, .trap_underflow, .fp_flags);
